/* include/psram_pkg.sv */
/*
 * constants for the pipelined synchronous sram command and data path.
 * assumes a single core clock and a synchronous host memory controller.
 */
`default_nettype none
package psram_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int ADDR_W  = 8;
   localparam int LANES   = 4;
   localparam int LANE_W  = 9;
   localparam int DATA_W  = LANES * LANE_W;
   localparam int DEPTH   = 256;
   localparam int BURST_W = 2;
   // ****************************************
   // reset values and pipeline depth
   // ****************************************
   localparam int PIPE_DEPTH = 2;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   localparam logic [BURST_W-1:0] COUNT_RESET = 2'h0;
   typedef enum logic [1:0] {
      PSRAM_IDLE  = 2'b00,
      PSRAM_READ  = 2'b01,
      PSRAM_WRITE = 2'b11
   } psram_op_t;
endpackage : psram_pkg
`default_nettype wire

/* rtl/psram_mem.sv */
/*
 * byte-lane writable memory array with registered read data.
 * assumes the caller gates both ports with the clock enable.
 */
`timescale 1ns/1ps
`default_nettype none
module psram_mem (
   // clock
   input  wire logic                                 core_clk,
   // access
   input  wire logic                                 en,
   input  wire logic                                 rd,
   input  wire logic [psram_pkg::ADDR_W-1:0]         addr,
   input  wire logic [psram_pkg::ADDR_W-1:0]         raddr,
   input  wire logic [psram_pkg::LANES-1:0]          lane_we,
   input  wire logic [psram_pkg::DATA_W-1:0]         wdata,
   output var  logic [psram_pkg::DATA_W-1:0]         rdata
);
   import psram_pkg::*;
   logic [DATA_W-1:0] mem [DEPTH];
   always_ff @(posedge core_clk) begin
      if (en) begin
         for (int i = 0; i < LANES; i++) begin
            if (lane_we[i]) begin
               mem[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
            end
         end
         if (rd) begin
            // separate read address: a landing write never steals a fetch
            rdata <= mem[raddr];
         end
      end
   end
endmodule : psram_mem
`default_nettype wire

/* rtl/psram_cmd_path.sv */
/*
 * command and data pipeline of a pipelined burst sram: load, burst,
 * deselect, no-op and suspend, data two enabled cycles after command.
 * assumes host inputs synchronous to core_clk; rst_n stands for power-up.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - load_or_advance high while enabled steps the internal burst counter during a burst
// - burst keeps read or write of its loading cycle
// - selected only with both low selects low and high select high
// - load_or_advance low while deselected starts deselect, no operation
// - data bus released two cycles after deselect edge
// - clock_gate_low high freezes every register but the reset synchroniser, and the data pins
// - data outputs are high impedance from first edge after power-up
// - scan logic stays disabled and never disturbs memory operation
// - read data driven, write data supplied, two cycles after command
// - burst_order_select high interleaves, low counts linearly modulo four
// - counter wraps to start value and keeps counting
// - each low byte lane strobe writes its lane including parity
module psram_cmd_path (
   // clock and reset
   input  wire logic                                 core_clk,
   input  wire logic                                 rst_n,
   // command
   input  wire logic                                 clock_gate_low,
   input  wire logic                                 load_or_advance,
   input  wire logic                                 read_write_n,
   input  wire logic                                 chip_select_a_low,
   input  wire logic                                 chip_select_b_low,
   input  wire logic                                 chip_select_high,
   input  wire logic                                 burst_order_select,
   input  wire logic [psram_pkg::ADDR_W-1:0]         addr,
   input  wire logic [psram_pkg::LANES-1:0]          byte_lane_write_low,
   // data pins
   input  wire logic [psram_pkg::DATA_W-1:0]         data_in,
   output var  logic [psram_pkg::DATA_W-1:0]         data_out,
   output var  logic                                 data_oe
);
   import psram_pkg::*;

   // ****************************************
   // reset synchroniser
   // ****************************************
   logic [1:0] rst_sync;
   logic       rst_int_n;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= SYNC_RESET;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync[1];

   // ****************************************
   // command decode
   // ****************************************
   logic enabled;
   logic selected;
   assign enabled  = !clock_gate_low;
   assign selected = !chip_select_a_low && !chip_select_b_low && chip_select_high;

   // ****************************************
   // address and burst state
   // ****************************************
   logic [ADDR_W-1:0]  base_addr, next_base_addr;
   logic [BURST_W-1:0] count, next_count;
   psram_op_t          op, next_op;
   logic [ADDR_W-1:0]  cur_addr;
   logic [BURST_W-1:0] low_bits;

   always_comb begin
      next_base_addr = base_addr;
      next_count     = count;
      next_op        = op;
      if (enabled) begin
         if (!load_or_advance) begin
            if (selected) begin
               next_base_addr = addr;
               next_count     = COUNT_RESET;
               next_op        = read_write_n ? PSRAM_READ : PSRAM_WRITE;
            end else begin
               next_op = PSRAM_IDLE;
            end
         end else if (op != PSRAM_IDLE) begin
            next_count = count + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         base_addr <= '0;
         count     <= COUNT_RESET;
         op        <= PSRAM_IDLE;
      end else begin
         base_addr <= next_base_addr;
         count     <= next_count;
         op        <= next_op;
      end
   end

   // ****************************************
   // this cycle's access address
   // ****************************************
   logic [BURST_W-1:0] step;
   logic               access;
   psram_op_t          cyc_op;
   always_comb begin
      cyc_op = PSRAM_IDLE;
      step   = '0;
      if (!load_or_advance) begin
         if (selected) begin
            cyc_op = read_write_n ? PSRAM_READ : PSRAM_WRITE;
         end
      end else if (op != PSRAM_IDLE) begin
         cyc_op = op;
         step   = count + 2'h1;
      end
   end
   assign access = enabled && (cyc_op != PSRAM_IDLE);
   always_comb begin
      if (!load_or_advance) begin
         low_bits = addr[BURST_W-1:0];
         cur_addr = addr;
      end else begin
         if (burst_order_select) begin
            low_bits = base_addr[BURST_W-1:0] ^ step;
         end else begin
            low_bits = base_addr[BURST_W-1:0] + step;
         end
         cur_addr = {base_addr[ADDR_W-1:BURST_W], low_bits};
      end
   end

   // ****************************************
   // two-stage data pipeline
   // ****************************************
   psram_op_t         p_op   [PIPE_DEPTH];
   psram_op_t         next_p_op [PIPE_DEPTH];
   logic [ADDR_W-1:0] p_addr [PIPE_DEPTH];
   logic [ADDR_W-1:0] next_p_addr [PIPE_DEPTH];
   logic              next_data_oe;
   logic [DATA_W-1:0] next_data_out;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] fwd_data;
   logic [DATA_W-1:0] next_fwd_data;
   logic [DATA_W-1:0] fwd_mask;
   logic [DATA_W-1:0] next_fwd_mask;
   logic              fetch;
   logic              fwd_hit;

   // read fetched one enabled edge before its data phase; a write landing
   // on that edge at the same word is not yet in the array, so its lanes
   // are captured here and merged into the output word
   assign fetch   = enabled && (p_op[0] == PSRAM_READ);
   assign fwd_hit = (p_op[1] == PSRAM_WRITE) && (p_addr[1] == p_addr[0]);

   always_comb begin
      next_p_op     = p_op;
      next_p_addr   = p_addr;
      next_data_oe  = data_oe;
      next_data_out = data_out;
      next_fwd_data = fwd_data;
      next_fwd_mask = fwd_mask;
      if (enabled) begin
         next_p_op[0]   = access ? cyc_op : PSRAM_IDLE;
         next_p_addr[0] = cur_addr;
         next_p_op[1]   = p_op[0];
         next_p_addr[1] = p_addr[0];
         next_data_oe   = (p_op[1] == PSRAM_READ);
         if (p_op[1] == PSRAM_READ) begin
            next_data_out = (rdata & ~fwd_mask) | (fwd_data & fwd_mask);
         end
      end
      if (fetch) begin
         next_fwd_data = data_in;
         for (int i = 0; i < LANES; i++) begin
            next_fwd_mask[i*LANE_W +: LANE_W] =
               {LANE_W{fwd_hit && !byte_lane_write_low[i]}};
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            p_op[i]   <= PSRAM_IDLE;
            p_addr[i] <= '0;
         end
         data_oe  <= 1'b0;
         data_out <= '0;
         fwd_data <= '0;
         fwd_mask <= '0;
      end else begin
         p_op     <= next_p_op;
         p_addr   <= next_p_addr;
         data_oe  <= next_data_oe;
         data_out <= next_data_out;
         fwd_data <= next_fwd_data;
         fwd_mask <= next_fwd_mask;
      end
   end

   // ****************************************
   // memory array
   // ****************************************
   logic [LANES-1:0]  lane_we;
   logic              mem_en;
   logic              mem_rd;
   // writes land in data phase at stage two, reads fetch stage one's word
   assign mem_en  = enabled;
   assign mem_rd  = (p_op[0] == PSRAM_READ);
   assign lane_we = (p_op[1] == PSRAM_WRITE) ? ~byte_lane_write_low : '0;

   psram_mem u_mem (
      .core_clk (core_clk),
      .en       (mem_en),
      .rd       (mem_rd),
      .addr     (p_addr[1]),
      .raddr    (p_addr[0]),
      .lane_we  (lane_we),
      .wdata    (data_in),
      .rdata    (rdata)
   );

   // no scan logic is built, so nothing can disturb the memory path
endmodule : psram_cmd_path
`default_nettype wire

/* sim/psram_host.sv */
/* host controller model: puts write data and lane strobes on the pins
   two enabled edges after a write command; assumes cmd_wr from the bench. */
`timescale 1ns/1ps
`default_nettype none
module psram_host import psram_pkg::*; (
   // clock
   input  wire logic                          core_clk,
   input  wire logic                          en,
   // command side
   input  wire logic                          cmd_wr,
   input  wire logic [psram_pkg::DATA_W-1:0]  cmd_wd,
   input  wire logic [psram_pkg::LANES-1:0]   cmd_ln,
   // pins
   output var  logic [psram_pkg::DATA_W-1:0]  data_in = '0,
   output var  logic [psram_pkg::LANES-1:0]   lanes_n = 4'hF
);
   logic [DATA_W+LANES:0] s1 = '0;
   logic [DATA_W+LANES:0] s2 = '0;
   always @(posedge core_clk) if (en) begin
      s2 <= s1;
      s1 <= {cmd_wr, cmd_ln, cmd_wd};
   end
   // outside a data phase the bus is released and toggles
   always @(negedge core_clk) begin
      data_in <= s2[DATA_W+LANES] ? s2[DATA_W-1:0] : ~data_in;
      lanes_n <= s2[DATA_W+LANES] ? s2[DATA_W+:LANES] : ~lanes_n;
   end
endmodule : psram_host
`default_nettype wire

/* sim/psram_cmd_path_chk.sv */
/* checker of the command pipeline ports; bound into psram_cmd_path. */
`timescale 1ns/1ps
`default_nettype none
module psram_cmd_path_chk (
   // clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   // command
   input  wire logic                          clock_gate_low,
   input  wire logic                          load_or_advance,
   input  wire logic                          read_write_n,
   input  wire logic                          chip_select_a_low,
   input  wire logic                          chip_select_b_low,
   input  wire logic                          chip_select_high,
   // data pins
   input  wire logic [psram_pkg::DATA_W-1:0]  data_out,
   input  wire logic                          data_oe
);
   wire en  = !clock_gate_low;
   wire sel = !chip_select_a_low && !chip_select_b_low && chip_select_high;
   wire ld  = en && !load_or_advance;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_hold_oe: assert property (clock_gate_low |=> $stable(data_oe))
      else $error("oe moved on suspended edge");
   a_hold_data: assert property (clock_gate_low |=> $stable(data_out))
      else $error("data moved on suspended edge");
   a_read_drives: assert property ((ld && sel && read_write_n) ##1 en[*2] |=> data_oe)
      else $error("read data phase not driven");
   a_write_quiet: assert property ((ld && sel && !read_write_n) ##1 en[*2] |=> !data_oe)
      else $error("bus driven in write data phase");
   a_desel_release: assert property ((ld && !sel) ##1 en[*2] |=> !data_oe)
      else $error("bus not released after deselect");
   a_noop_release: assert property ((ld && !sel) ##1 (en && load_or_advance) ##1 en[*2]
      |=> !data_oe)
      else $error("advance after deselect drove bus");
   a_burst_read: assert property ((ld && sel && read_write_n) ##1 (en && load_or_advance)
      ##1 en[*2] |=> data_oe)
      else $error("burst read not driven");
   a_oe_on_enabled: assert property ($rose(data_oe) |-> $past(en))
      else $error("oe rose on suspended edge");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !data_oe)
      else $error("bus driven under power-up reset");
endmodule : psram_cmd_path_chk
bind psram_cmd_path psram_cmd_path_chk u_chk (.core_clk, .rst_n, .clock_gate_low,
   .load_or_advance, .read_write_n, .chip_select_a_low, .chip_select_b_low,
   .chip_select_high, .data_out, .data_oe);
`default_nettype wire

/* sim/testbench.sv */
/* self-checking bench: random and hand-made command streams against a
   reference pipeline; assumes psram_host supplies write data. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import psram_pkg::*;
   logic               core_clk = 0, rst_n = 0, cgl = 0, lo = 0, rw = 1, bos = 0;
   logic               ca = 1, cb = 1, ch = 0, data_oe, exp_oe = 0;
   logic [ADDR_W-1:0]  addr = '0, bstart = '0;
   logic [LANES-1:0]   cmd_ln = 4'hF, lanes_n;
   logic [DATA_W-1:0]  cmd_wd = '0, data_in, data_out, exp_d = '0;
   logic [DATA_W-1:0]  ref_mem [DEPTH];
   logic [1:0]         bop = '0, bcnt = '0;
   logic [9:0]         p1 = '0, p2 = '0;
   int                 bad_count = 0, n_tests = 0, seed = 32'hc35ce703, r;
   wire                sel = !ca && !cb && ch;
   wire                wr_now = lo ? (bop == 2'h2) : (sel && !rw);
   always #20 core_clk = ~core_clk;
   psram_host u_host (.core_clk, .en(!cgl), .cmd_wr(wr_now), .cmd_wd, .cmd_ln,
      .data_in, .lanes_n);
   psram_cmd_path dut (.core_clk, .rst_n, .clock_gate_low(cgl), .load_or_advance(lo),
      .read_write_n(rw), .chip_select_a_low(ca), .chip_select_b_low(cb),
      .chip_select_high(ch), .burst_order_select(bos), .addr,
      .byte_lane_write_low(lanes_n), .data_in, .data_out, .data_oe);
   // ****************************************
   // expectations
   // ****************************************
   function automatic logic [ADDR_W-1:0] baddr(logic [ADDR_W-1:0] s, logic [1:0] c, logic il);
      baddr = {s[ADDR_W-1:2], il ? (s[1:0] ^ c) : (s[1:0] + c)};
   endfunction : baddr
   function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, n, logic [LANES-1:0] l);
      merge = o;
      for (int i = 0; i < LANES; i++) if (!l[i]) merge[i*LANE_W+:LANE_W] = n[i*LANE_W+:LANE_W];
   endfunction : merge
   task automatic check(logic [DATA_W-1:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   always @(posedge core_clk) begin
      logic [9:0] cur;
      cur = '0;
      if (!rst_n) begin
         bop <= '0; p1 <= '0; p2 <= '0; exp_oe <= 0;
      end else if (!cgl) begin
         if (!lo) begin
            bop <= sel ? (rw ? 2'h1 : 2'h2) : 2'h0;
            bstart <= addr;
            bcnt <= '0;
            if (sel) cur = {(rw ? 2'h1 : 2'h2), addr};
         end else if (bop != 2'h0) begin
            bcnt <= bcnt + 2'h1;
            cur = {bop, baddr(bstart, bcnt + 2'h1, bos)};
         end
         if (p2[9:8] == 2'h2) ref_mem[p2[7:0]] = merge(ref_mem[p2[7:0]], data_in, lanes_n);
         exp_oe <= (p2[9:8] == 2'h1);
         if (p2[9:8] == 2'h1) exp_d <= ref_mem[p2[7:0]];
         p2 <= p1;
         p1 <= cur;
      end
      #1;
      check(DATA_W'(data_oe), DATA_W'(exp_oe));
      if (exp_oe) check(data_out, exp_d);
   end
   // ****************************************
   // stimulus
   // ****************************************
   task automatic drive(logic g, l, w, logic [2:0] cs, logic [ADDR_W-1:0] a, logic [3:0] ln);
      @(negedge core_clk);
      {cgl, lo, rw, ca, cb, ch, addr, cmd_ln} = {g, l, w, cs, a, ln};
      cmd_wd = DATA_W'({$random(seed), $random(seed)});
   endtask : drive
   task automatic wrap_up;
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (12) @(negedge core_clk);
      rst_n = 1;
      repeat (3) drive(0, 0, 1, 3'b110, '0, 4'hF);
      for (int i = 0; i < DEPTH; i++) drive(0, 0, 0, 3'b001, ADDR_W'(i), 4'h0);
      for (int k = 0; k < 2; k++) begin
         repeat (3) drive(0, 0, 1, 3'b110, '0, 4'hF);
         bos = k[0];
         drive(0, 0, 1, 3'b001, 8'h7E, 4'hF);
         repeat (6) drive(0, 1, 0, 3'b110, '0, 4'h0);
         drive(1, 0, 0, 3'b001, 8'h11, 4'h0);
         drive(0, 0, 0, 3'b001, 8'h12, 4'h5);
         drive(0, 0, 1, 3'b001, 8'h12, 4'hF);
         repeat (1500) begin
            r = $random(seed);
            drive(r[2:0] == 0, r[3], r[4], (r[7:5] == 0) ? r[10:8] : 3'b001, r[18:11], r[24:21]);
         end
      end
      repeat (4) drive(0, 0, 1, 3'b110, '0, 4'hF);
      wrap_up;
   end
   initial begin
      #(8000 * 40);
      bad_count++;
      wrap_up;
   end
endmodule : testbench
`default_nettype wire
